// ==== verilog/sdpwr_pkg.sv ====
// Constants and carrier types for the clock-enable power-state block.
// Assumes one system clock; command pins arrive from the controller.
package sdpwr_pkg;
    localparam int SDPWR_STATE_W = 3;
    localparam int SDPWR_BANKS = 8;
    localparam int SDPWR_XS_CYC_DEF = 8;
    localparam int SDPWR_WR_WAIT_CYC = 512;
    localparam logic [3:0] SDPWR_CMD_REF = 4'h1; // cs,ras,cas,we = 0001
    localparam logic [3:0] SDPWR_CMD_NOP = 4'h7;

    typedef enum logic [2:0] {
        SDPWR_IDLE = 3'b000,
        SDPWR_ACTIVE = 3'b001,
        SDPWR_ACT_PD = 3'b010,
        SDPWR_PRE_PD = 3'b011,
        SDPWR_SELF_REF = 3'b100
    } sdpwr_state_type;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic cke;
    } sdpwr_pins_type;

    typedef struct packed {
        sdpwr_pins_type s1;
        sdpwr_pins_type s2;
        logic cke_prev;
        sdpwr_state_type state;
        logic [9:0] xs_cnt;
        logic [9:0] wr_cnt;
        logic odt_ok;
        logic refresh_ok;
    } sdpwr_all_type;
endpackage : sdpwr_pkg

// ==== verilog/sdpwr_ctrl.sv ====
// Clock-enable power-state tracker of the memory device.
// Assumes pins from the controller are asynchronous to clk_sys.
`timescale 1ns/1ps
module sdpwr_ctrl
    import sdpwr_pkg::*;
#(
    parameter int XS_CYC = SDPWR_XS_CYC_DEF
) (
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic cs_n_pin, // Chip select, active low
    input wire logic ras_n_pin, // Row strobe, active low
    input wire logic cas_n_pin, // Column strobe, active low
    input wire logic we_n_pin, // Write enable, active low
    input wire logic cke_pin, // Clock enable
    input wire logic banks_open, // Any bank open, from bank logic
    output logic [2:0] state_reg, // Encoded power state
    output logic odt_ok_reg, // Termination may be used
    output logic refresh_ok_reg, // Internal refresh allowed
    output logic xs_busy_reg, // Self-refresh exit delay running
    output logic wr_block_reg // Writes still blocked after exit
);
    sdpwr_all_type all_reg, all_next;
    logic nop_like;
    logic refresh_cmd;

    // Deselect counts as nop; command fields from second sync stage
    always_comb begin
        nop_like = all_reg.s2.cs_n ||
            ({all_reg.s2.cs_n, all_reg.s2.ras_n, all_reg.s2.cas_n, all_reg.s2.we_n} == SDPWR_CMD_NOP);
        refresh_cmd = {all_reg.s2.cs_n, all_reg.s2.ras_n, all_reg.s2.cas_n, all_reg.s2.we_n} == SDPWR_CMD_REF;
    end

    // Next state: enable level pair plus command selects action
    always_comb begin
        all_next = all_reg;
        all_next.s1 = {cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin, cke_pin};
        all_next.s2 = all_reg.s1;
        all_next.cke_prev = all_reg.s2.cke;
        if (all_reg.xs_cnt != 10'h000) all_next.xs_cnt = all_reg.xs_cnt - 10'h001;
        if (all_reg.wr_cnt != 10'h000) all_next.wr_cnt = all_reg.wr_cnt - 10'h001;
        case (all_reg.state)
            SDPWR_IDLE, SDPWR_ACTIVE: begin
                if (all_reg.cke_prev && !all_reg.s2.cke) begin
                    if (refresh_cmd && all_reg.state == SDPWR_IDLE && all_reg.xs_cnt == 10'h000)
                        all_next.state = SDPWR_SELF_REF;
                    else if (nop_like)
                        all_next.state = banks_open ? SDPWR_ACT_PD : SDPWR_PRE_PD;
                end else begin
                    all_next.state = banks_open ? SDPWR_ACTIVE : SDPWR_IDLE;
                end
            end
            SDPWR_ACT_PD, SDPWR_PRE_PD: begin
                // Low-low holds regardless of command pins
                if (!all_reg.cke_prev && all_reg.s2.cke)
                    all_next.state = banks_open ? SDPWR_ACTIVE : SDPWR_IDLE;
            end
            SDPWR_SELF_REF: begin
                // Exit keyed on enable rising, command not decoded
                if (!all_reg.cke_prev && all_reg.s2.cke) begin
                    all_next.state = SDPWR_IDLE;
                    all_next.xs_cnt = 10'(XS_CYC);
                    all_next.wr_cnt = 10'(SDPWR_WR_WAIT_CYC);
                end
            end
            default: all_next.state = SDPWR_IDLE;
        endcase
        // No refresh in power-down; no termination in self-refresh
        all_next.refresh_ok = !(all_next.state == SDPWR_ACT_PD || all_next.state == SDPWR_PRE_PD);
        all_next.odt_ok = all_next.state != SDPWR_SELF_REF && all_next.xs_cnt == 10'h000;
    end

    // Single state register for the whole block
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            all_reg <= '0;
        end else begin
            all_reg <= all_next;
        end
    end

    // Outputs from flops of the state record; busy and block flags decode the counters
    always_comb begin
        state_reg = all_reg.state;
        odt_ok_reg = all_reg.odt_ok;
        refresh_ok_reg = all_reg.refresh_ok;
        xs_busy_reg = all_reg.xs_cnt != 10'h000;
        wr_block_reg = all_reg.wr_cnt != 10'h000;
    end

    chk_sr_exit_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (all_reg.state == SDPWR_SELF_REF && !all_reg.cke_prev && all_reg.s2.cke) |=> state_reg == SDPWR_IDLE)
        else $error("self-refresh exit missed");
    chk_hold_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (all_reg.state inside {SDPWR_ACT_PD, SDPWR_PRE_PD, SDPWR_SELF_REF} && !all_reg.cke_prev && !all_reg.s2.cke)
        |=> $stable(state_reg))
        else $error("state moved while enable low");
    chk_sr_entry_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_reg != SDPWR_SELF_REF) ##1 (state_reg == SDPWR_SELF_REF) |-> $past(state_reg) == SDPWR_IDLE)
        else $error("self-refresh entered from non-idle");
    chk_pd_kind: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (all_reg.state == SDPWR_ACTIVE && all_reg.cke_prev && !all_reg.s2.cke && nop_like && banks_open)
        |=> state_reg == SDPWR_ACT_PD)
        else $error("active power-down not entered");
    chk_pd_closed: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (all_reg.state == SDPWR_IDLE && all_reg.cke_prev && !all_reg.s2.cke && nop_like && !banks_open)
        |=> state_reg == SDPWR_PRE_PD)
        else $error("precharge power-down not entered");
    chk_no_refresh: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_reg inside {SDPWR_ACT_PD, SDPWR_PRE_PD} |-> !refresh_ok_reg)
        else $error("refresh allowed in power-down");
    chk_odt_sr: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_reg == SDPWR_SELF_REF || xs_busy_reg) |-> !odt_ok_reg)
        else $error("termination allowed in self-refresh");
    chk_wr_wait: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(wr_block_reg) |-> wr_block_reg [*8])
        else $error("write block released early");
    chk_cke_pair: assert property (@(posedge clk_sys) disable iff (!rst_n)
        all_reg.s2.cke |=> all_reg.cke_prev)
        else $error("previous enable not kept");
    // A falling enable with any other command must not move into a low-power state
    chk_bad_entry: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (all_reg.state inside {SDPWR_IDLE, SDPWR_ACTIVE} && all_reg.cke_prev && !all_reg.s2.cke && !nop_like && !refresh_cmd)
        |=> state_reg inside {SDPWR_IDLE, SDPWR_ACTIVE})
        else $error("entry taken on an illegal command");
    // Refresh entry is refused while the exit delay still runs
    chk_sr_after_xs: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (all_reg.state == SDPWR_IDLE && all_reg.xs_cnt != 10'h000) |=> state_reg != SDPWR_SELF_REF)
        else $error("self-refresh entered during exit delay");
    cov_sr: cover property (@(posedge clk_sys) disable iff (!rst_n) state_reg == SDPWR_SELF_REF);
    cov_apd: cover property (@(posedge clk_sys) disable iff (!rst_n) state_reg == SDPWR_ACT_PD);
    cov_ppd: cover property (@(posedge clk_sys) disable iff (!rst_n) state_reg == SDPWR_PRE_PD);
    cov_srx: cover property (@(posedge clk_sys) disable iff (!rst_n) $fell(xs_busy_reg));
endmodule : sdpwr_ctrl

// ==== test/sdpwr_ctl_model.sv ====
// Controller-side model: drives command strobes and clock enable.
// Assumes the bench calls its tasks; pins change 1 ns after clk_sys rises.
`timescale 1ns/1ps
module sdpwr_ctl_model
    import sdpwr_pkg::*;
(
    input wire logic clk_sys, // System clock
    output sdpwr_pins_type pins // Strobes and clock enable
);
    // Start deselected with enable high; mode delays counted as met
    initial begin
        pins = {4'hf, 1'b1};
    end
    // One command with an enable level, held so the synchroniser sees it
    task automatic send(input logic [3:0] cmd, input logic cke, input int hold);
        @(posedge clk_sys);
        #1;
        pins[4:1] = cmd;
        pins.cke = cke;
        repeat (hold) @(posedge clk_sys);
    endtask : send
    // Strobes float while enable stays low: a pattern changing each cycle
    task automatic float_cmds(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            #1;
            pins[4:1] = ~pins[4:1];
        end
    endtask : float_cmds
endmodule : sdpwr_ctl_model

// ==== test/testbench.sv ====
// Self-checking bench for the clock-enable power-state block.
// Assumes the controller model above; short exit delay for run time.
`timescale 1ns/1ps
module testbench;
    import sdpwr_pkg::*;
    localparam int XS = 4;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic banks_open = 1'b0;
    sdpwr_pins_type pins;
    logic [2:0] state;
    logic odt_ok, refresh_ok, xs_busy, wr_block;
    int num_errors = 0;
    int num_checks = 0;
    // Clock and parts
    always #20 clk_sys = ~clk_sys;
    sdpwr_ctl_model u_ctl (.clk_sys(clk_sys), .pins(pins));
    sdpwr_ctrl #(.XS_CYC(XS)) i_sdpwr_ctrl (.clk_sys(clk_sys), .rst_n(rst_n), .cs_n_pin(pins.cs_n),
        .ras_n_pin(pins.ras_n), .cas_n_pin(pins.cas_n), .we_n_pin(pins.we_n), .cke_pin(pins.cke),
        .banks_open(banks_open), .state_reg(state), .odt_ok_reg(odt_ok), .refresh_ok_reg(refresh_ok),
        .xs_busy_reg(xs_busy), .wr_block_reg(wr_block));
    task automatic check(input logic [2:0] seen, input logic [2:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: seen %b expected %b", $time, seen, exp);
        end
    endtask : check
    // Two sync stages plus decision, one spare edge
    task automatic settle();
        repeat (4) @(posedge clk_sys);
        #1;
    endtask : settle
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop
    // Outputs low in reset, refresh and termination allowed after
    task automatic t_reset();
        repeat (5) @(posedge clk_sys);
        check(state, SDPWR_IDLE);
        check(refresh_ok, 1'b0);
        #1 rst_n = 1'b1;
        settle();
        check(refresh_ok, 1'b1);
        check(odt_ok, 1'b1);
    endtask : t_reset
    // Idle entry gives precharge power-down; floating strobes ignored
    task automatic t_pre_pd();
        u_ctl.send(SDPWR_CMD_NOP, 1'b0, 3);
        settle();
        check(state, SDPWR_PRE_PD);
        check(refresh_ok, 1'b0);
        u_ctl.float_cmds(6);
        check(state, SDPWR_PRE_PD);
        u_ctl.send(SDPWR_CMD_NOP, 1'b1, 3);
        settle();
        check(state, SDPWR_IDLE);
    endtask : t_pre_pd
    // Enable falling with a read command is not an entry
    task automatic t_refused();
        u_ctl.send(4'h5, 1'b0, 3);
        settle();
        check(state, SDPWR_IDLE);
        u_ctl.send(SDPWR_CMD_NOP, 1'b1, 3);
        settle();
    endtask : t_refused
    // Self-refresh entry, exit from enable rise, exit delays
    task automatic t_self_ref();
        u_ctl.send(SDPWR_CMD_REF, 1'b0, 3);
        settle();
        check(state, SDPWR_SELF_REF);
        check(odt_ok, 1'b0);
        u_ctl.float_cmds(4);
        u_ctl.send(SDPWR_CMD_NOP, 1'b1, 1);
        settle();
        check(state, SDPWR_IDLE);
        check({xs_busy, wr_block}, 2'b11);
        repeat (XS + 2) @(posedge clk_sys);
        #1 check(xs_busy, 1'b0);
        @(posedge clk_sys);
        #1 check(odt_ok, 1'b1);
        repeat (502) @(posedge clk_sys);
        #1 check(wr_block, 1'b1);
        @(posedge clk_sys);
        #1 check(wr_block, 1'b0);
    endtask : t_self_ref
    // Open bank: deselect entry is active power-down; refresh cannot self-refresh
    task automatic t_act_pd();
        banks_open = 1'b1;
        u_ctl.send(4'hf, 1'b0, 3);
        settle();
        check(state, SDPWR_ACT_PD);
        u_ctl.send(SDPWR_CMD_NOP, 1'b1, 3);
        settle();
        check(state, SDPWR_ACTIVE);
        u_ctl.send(SDPWR_CMD_REF, 1'b0, 3);
        settle();
        check(state, SDPWR_ACTIVE);
    endtask : t_act_pd
    initial begin
        t_reset();
        t_pre_pd();
        t_refused();
        t_self_ref();
        t_act_pd();
        report_and_stop();
    end
    // Watchdog: run needs under 1000 cycles
    initial begin
        #(3000 * 40);
        num_errors++;
        report_and_stop();
    end
endmodule : testbench
